/* smc_pkg.sv */
// smc_pkg: constants and carrier types for the supply monitor control block
// assumes: included first; every user refers to names as smc_pkg::name
`default_nettype none
package smc_pkg;
    // register offsets on the plain register port
    localparam logic [7:0] OFF_LEVEL_STATUS = 8'h31;
    localparam logic [7:0] OFF_DETECT_ENABLE = 8'h32;
    localparam logic [7:0] OFF_CH0_CONTROL = 8'h38;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h3c;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h3d;
    localparam logic [7:0] OFF_PROTECT = 8'h3e;
    // field positions
    localparam int LS_CH2_LEVEL = 3;
    localparam int DE_LOW_CONS = 0;
    localparam int DE_DET0 = 5;
    localparam int DE_DET1 = 6;
    localparam int DE_DET2 = 7;
    localparam int C0_RESET_EN = 0;
    localparam int C0_BYPASS = 1;
    localparam int C0_RSVD_RO = 3;
    localparam int C0_DIV_LO = 4;
    localparam int C0_CONDITION = 7;
    // writable bits of each register
    localparam logic [7:0] DE_WMASK = 8'he1;
    localparam logic [7:0] C0_WMASK = 8'hf3;
    // reset values
    localparam logic [7:0] DE_RST_OPT1 = 8'h00;
    localparam logic [7:0] DE_RST_OPT0 = 8'h20;
    localparam logic [7:0] C0_RST_OPT1 = 8'h00;
    localparam logic [7:0] C0_RST_OPT0 = 8'h41;
    localparam logic [7:0] LS_RST = 8'h08;
    // interrupt status bits
    localparam int IRQ_CH0 = 0;
    localparam int IRQ_CH1 = 1;
    localparam int IRQ_CH2 = 2;
    localparam int IRQ_W = 3;
    // timing
    localparam int SYS_CLK_HZ = 50_000_000;
    localparam int EN_DELAY_US = 100;
    localparam int EN_DELAY_CYC = (EN_DELAY_US * (SYS_CLK_HZ / 1_000_000) > 0) ?
                                  EN_DELAY_US * (SYS_CLK_HZ / 1_000_000) : 1;
    localparam int FILT_SAMPLES = 4;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } smc_bus_req_t;

    typedef struct packed {
        logic [7:0]     rdata;
        logic [7:0]     detect_enable;
        logic [7:0]     ch0_control;
        logic           protect_release;
        logic [IRQ_W-1:0] irq_status;
        logic [IRQ_W-1:0] irq_mask;
        logic           irq;
        logic           ch0_reset_req;
        logic [2:0]     det_active;
        logic [2:0]     level;
        logic           opt_taken;
    } smc_state_t;
endpackage
`default_nettype wire

/* smc_channel.sv */
// smc_channel: start-up wait and level tracking for one detection channel
// assumes: cmp_sync already brought onto sys_clk; tick is a one-cycle sample strobe
`default_nettype none
module smc_channel #(
    parameter int DELAY_CYC = smc_pkg::EN_DELAY_CYC
) (
    input  wire logic sys_clk,
    input  wire logic reset,
    input  wire logic enable,
    input  wire logic cmp_sync,
    input  wire logic bypass,
    input  wire logic tick,
    output logic      active,
    output logic      level
);
    typedef enum logic [1:0] {SMC_OFF, SMC_WAIT, SMC_RUN} smc_ch_st_t;

    typedef struct packed {
        smc_ch_st_t  st;
        logic [31:0] cnt;
        logic [1:0]  same;
        logic        level;
    } smc_ch_t;

    smc_ch_t s_r;
    smc_ch_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        case (s_r.st)
            SMC_OFF: begin
                s_nxt.level = 1'b1;
                s_nxt.same = 2'h0;
                if (enable) begin
                    s_nxt.st = SMC_WAIT;
                    s_nxt.cnt = 32'h0;
                end
            end
            SMC_WAIT: begin
                s_nxt.cnt = s_r.cnt + 32'h1;
                if (!enable) begin
                    s_nxt.st = SMC_OFF;
                end else if (s_r.cnt >= 32'(DELAY_CYC - 1)) begin
                    s_nxt.st = SMC_RUN;
                end
            end
            SMC_RUN: begin
                if (!enable) begin
                    s_nxt.st = SMC_OFF;
                    s_nxt.level = 1'b1;
                end else if (bypass) begin
                    s_nxt.level = cmp_sync;
                end else if (tick) begin
                    // level moves only after four agreeing samples
                    if (cmp_sync == s_r.level) begin
                        s_nxt.same = 2'h0;
                    end else if (s_r.same == 2'(smc_pkg::FILT_SAMPLES - 1)) begin
                        s_nxt.level = cmp_sync;
                        s_nxt.same = 2'h0;
                    end else begin
                        s_nxt.same = s_r.same + 2'h1;
                    end
                end
            end
            default: s_nxt.st = SMC_OFF;
        endcase
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            s_r <= '{st: SMC_OFF, cnt: 32'h0, same: 2'h0, level: 1'b1};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign active = (s_r.st == SMC_RUN);
    assign level = s_r.level;
endmodule
`default_nettype wire

/* smc_top.sv */
// smc_top: register file and control for a three-channel supply monitor
// assumes: comparator inputs are asynchronous; slow_oscillator_clock is a sampled pin
// Behaviour
// - channel-2 flag reads 0 below second threshold, 1 at or above
// - channel-2 flag tracks comparator only while det2_enable is 1
// - channel-2 flag forced to 1 while det2_enable is 0
// - level status and enables survive software, watchdog, monitor-1/2 resets
// - monitor-0 reset generation works only while det0_enable is 1
// - monitor-1 event and channel-1 flag work only while det1_enable is 1
// - monitor-2 event and channel-2 flag work only while det2_enable is 1
// - a channel enabled 0 to 1 waits the enable delay before operating
// - channel-0 bit 1: 0 keeps filter, 1 bypasses it
// - channel-0 bits 5:4 divide slow oscillator by 1, 2, 4 or 8
// - channel-0 bit 3 read-only undefined; bit 2 reserved, written 0
// - channel-0 control resets per start-up option: 0000X000b or 0100X001b
// - filter sample period is one divided slow-oscillator period; four samples move the level
//
// The strobed register port is this design's own decision.
`default_nettype none
module smc_top #(
    parameter int DELAY_CYC = smc_pkg::EN_DELAY_CYC
) (
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic       soft_reset,
    input  wire logic       startup_det0_option,
    input  wire logic       slow_oscillator_clock,
    input  wire logic [2:0] cmp_above,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    output logic            irq,
    output logic            ch0_reset_req,
    output logic            low_consumption_enable
);
    smc_pkg::smc_state_t s_r;
    smc_pkg::smc_state_t s_nxt;
    smc_pkg::smc_bus_req_t req;

    logic [2:0] cmp_m_r;
    logic [2:0] cmp_s_r;
    logic [1:0] osc_m_r;
    logic       osc_d_r;
    logic [2:0] div_cnt_r;
    logic       tick_r;
    logic [2:0] ch_active;
    logic [2:0] ch_level;
    logic [2:0] level_q_r;
    logic       osc_rise;
    logic [2:0] div_mask;
    logic [1:0] opt_sync_r;
    logic [1:0] soft_sync_r;

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // two-flop synchronisers for comparators and slow oscillator
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cmp_m_r <= 3'h7;
            cmp_s_r <= 3'h7;
            osc_m_r <= 2'h0;
            osc_d_r <= 1'b0;
        end else begin
            cmp_m_r <= cmp_above;
            cmp_s_r <= cmp_m_r;
            osc_m_r <= {osc_m_r[0], slow_oscillator_clock};
            osc_d_r <= osc_m_r[1];
        end
    end

    assign osc_rise = osc_m_r[1] & ~osc_d_r;

    // strap pin settles through two flops; no reset, so it is valid as reset lifts
    always_ff @(posedge sys_clk) begin
        opt_sync_r <= {opt_sync_r[0], startup_det0_option};
    end

    // divided slow clock: tick every 1, 2, 4 or 8 oscillator rising edges
    always_comb begin
        case (s_r.ch0_control[smc_pkg::C0_DIV_LO +: 2])
            2'h0: div_mask = 3'h0;
            2'h1: div_mask = 3'h1;
            2'h2: div_mask = 3'h3;
            default: div_mask = 3'h7;
        endcase
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            div_cnt_r <= 3'h0;
            tick_r <= 1'b0;
        end else begin
            tick_r <= 1'b0;
            if (osc_rise) begin
                div_cnt_r <= (div_cnt_r + 3'h1) & div_mask;
                tick_r <= ((div_cnt_r & div_mask) == div_mask);
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_ch
            smc_channel #(
                .DELAY_CYC(DELAY_CYC)
            ) u_ch (
                .sys_clk (sys_clk),
                .reset   (reset),
                .enable  (s_r.detect_enable[smc_pkg::DE_DET0 + gi]),
                .cmp_sync(cmp_s_r[gi]),
                .bypass  (s_r.ch0_control[smc_pkg::C0_BYPASS]),
                .tick    (tick_r),
                .active  (ch_active[gi]),
                .level   (ch_level[gi])
            );
        end
    endgenerate

    always_comb begin
        logic       wr_de;
        logic       wr_c0;
        logic [2:0] fall;
        wr_de = 1'b0;
        wr_c0 = 1'b0;
        fall = 3'h0;
        s_nxt = s_r;
        s_nxt.rdata = 8'h00;
        s_nxt.det_active = ch_active;
        s_nxt.level = ch_level;
        // strap caught on first clock after reset release
        if (!s_r.opt_taken) begin
            s_nxt.opt_taken = 1'b1;
            s_nxt.detect_enable = opt_sync_r[1] ? smc_pkg::DE_RST_OPT1
                                                : smc_pkg::DE_RST_OPT0;
            s_nxt.ch0_control = opt_sync_r[1] ? smc_pkg::C0_RST_OPT1
                                              : smc_pkg::C0_RST_OPT0;
        end
        wr_de = req.wr && req.addr == smc_pkg::OFF_DETECT_ENABLE && s_r.protect_release;
        wr_c0 = req.wr && req.addr == smc_pkg::OFF_CH0_CONTROL && s_r.protect_release;
        if (wr_de) begin
            s_nxt.detect_enable = req.wdata & smc_pkg::DE_WMASK;
        end
        if (wr_c0) begin
            s_nxt.ch0_control = req.wdata & smc_pkg::C0_WMASK;
        end
        if (req.wr && req.addr == smc_pkg::OFF_PROTECT) begin
            s_nxt.protect_release = req.wdata[0];
        end
        if (req.wr && req.addr == smc_pkg::OFF_IRQ_MASK) begin
            s_nxt.irq_mask = req.wdata[smc_pkg::IRQ_W-1:0];
        end
        if (req.wr && req.addr == smc_pkg::OFF_IRQ_STATUS) begin
            s_nxt.irq_status = s_r.irq_status & ~req.wdata[smc_pkg::IRQ_W-1:0];
        end
        // events: falling level on an active channel; set beats clear
        fall = s_r.level & ~ch_level & ch_active & s_r.det_active;
        s_nxt.irq_status = s_nxt.irq_status | fall;
        s_nxt.irq = |(s_nxt.irq_status & s_nxt.irq_mask);
        s_nxt.ch0_reset_req = ch_active[0] && !ch_level[0]
                              && s_r.detect_enable[smc_pkg::DE_DET0]
                              && s_r.ch0_control[smc_pkg::C0_RESET_EN];
        if (req.rd) begin
            case (req.addr)
                smc_pkg::OFF_LEVEL_STATUS: begin
                    s_nxt.rdata = 8'h00;
                    // reads 1 unless channel 2 is running and below threshold
                    s_nxt.rdata[smc_pkg::LS_CH2_LEVEL] =
                        ~(s_r.detect_enable[smc_pkg::DE_DET2] & ch_active[2])
                        | ch_level[2];
                end
                smc_pkg::OFF_DETECT_ENABLE: s_nxt.rdata = s_r.detect_enable;
                smc_pkg::OFF_CH0_CONTROL: s_nxt.rdata = s_r.ch0_control; // bit 3 reads 0
                smc_pkg::OFF_IRQ_STATUS: s_nxt.rdata = {5'h00, s_r.irq_status};
                smc_pkg::OFF_IRQ_MASK: s_nxt.rdata = {5'h00, s_r.irq_mask};
                smc_pkg::OFF_PROTECT: s_nxt.rdata = {7'h00, s_r.protect_release};
                default: s_nxt.rdata = 8'h00;
            endcase
        end
    end

    // only the hard reset clears this state; soft resets leave it alone
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // soft resets are only watched here; every register rides through them
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            soft_sync_r <= 2'h0;
        end else begin
            soft_sync_r <= {soft_sync_r[0], soft_reset};
        end
    end

    assign reg_rdata = s_r.rdata;
    assign irq = s_r.irq;
    assign ch0_reset_req = s_r.ch0_reset_req;
    assign low_consumption_enable = s_r.detect_enable[smc_pkg::DE_LOW_CONS];

    property p_locked_write;
        @(posedge sys_clk) disable iff (reset)
        (reg_wr && reg_addr == smc_pkg::OFF_DETECT_ENABLE && !s_r.protect_release
         && s_r.opt_taken) |=> $stable(s_r.detect_enable);
    endproperty
    a_locked_write: assert property (p_locked_write) else $error("locked write landed");

    property p_ch2_off_reads_one;
        @(posedge sys_clk) disable iff (reset)
        (reg_rd && reg_addr == smc_pkg::OFF_LEVEL_STATUS
         && !s_r.detect_enable[smc_pkg::DE_DET2]) |=> reg_rdata[smc_pkg::LS_CH2_LEVEL];
    endproperty
    a_ch2_off_reads_one: assert property (p_ch2_off_reads_one) else $error("flag not 1");

    property p_ch2_tracks;
        @(posedge sys_clk) disable iff (reset)
        (reg_rd && reg_addr == smc_pkg::OFF_LEVEL_STATUS && ch_active[2]
         && s_r.detect_enable[smc_pkg::DE_DET2])
        |=> reg_rdata[smc_pkg::LS_CH2_LEVEL] == $past(ch_level[2]);
    endproperty
    a_ch2_tracks: assert property (p_ch2_tracks) else $error("flag not tracking");

    property p_ch0_reset_gated;
        @(posedge sys_clk) disable iff (reset)
        ch0_reset_req |-> $past(s_r.detect_enable[smc_pkg::DE_DET0]);
    endproperty
    a_ch0_reset_gated: assert property (p_ch0_reset_gated) else $error("reset while off");

    property p_no_early_active;
        @(posedge sys_clk) disable iff (reset)
        $rose(s_r.detect_enable[smc_pkg::DE_DET1]) |-> !ch_active[1] [*2];
    endproperty
    a_no_early_active: assert property (p_no_early_active) else $error("active too soon");

    property p_ch1_event_gated;
        @(posedge sys_clk) disable iff (reset)
        $rose(s_r.irq_status[smc_pkg::IRQ_CH1]) |-> $past(ch_active[1], 2);
    endproperty
    a_ch1_event_gated: assert property (p_ch1_event_gated) else $error("ch1 event off");

    property p_ch2_event_gated;
        @(posedge sys_clk) disable iff (reset)
        $rose(s_r.irq_status[smc_pkg::IRQ_CH2]) |-> $past(ch_active[2], 2);
    endproperty
    a_ch2_event_gated: assert property (p_ch2_event_gated) else $error("ch2 event off");

    property p_rsvd_zero;
        @(posedge sys_clk) disable iff (reset)
        s_r.opt_taken |-> s_r.ch0_control[3:2] == 2'h0;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits set");

    property p_strap;
        @(posedge sys_clk) disable iff (reset)
        $rose(s_r.opt_taken) |-> s_r.ch0_control == ($past(opt_sync_r[1]) ?
            smc_pkg::C0_RST_OPT1 : smc_pkg::C0_RST_OPT0);
    endproperty
    a_strap: assert property (p_strap) else $error("bad reset value");

    property p_soft_keeps;
        @(posedge sys_clk) disable iff (reset)
        (soft_sync_r[1] && !reg_wr && s_r.opt_taken)
        |=> $stable(s_r.detect_enable) && $stable(s_r.ch0_control);
    endproperty
    a_soft_keeps: assert property (p_soft_keeps) else $error("soft reset touched state");

    property p_ch2_idle;
        @(posedge sys_clk) disable iff (reset)
        (reg_rd && reg_addr == smc_pkg::OFF_LEVEL_STATUS && !ch_active[2])
        |=> reg_rdata[smc_pkg::LS_CH2_LEVEL];
    endproperty
    a_ch2_idle: assert property (p_ch2_idle) else $error("idle flag not 1");

    property p_bypass_follows;
        @(posedge sys_clk) disable iff (reset)
        (ch_active[1] && s_r.detect_enable[smc_pkg::DE_DET1]
         && s_r.ch0_control[smc_pkg::C0_BYPASS]) |=> ch_level[1] == $past(cmp_s_r[1]);
    endproperty
    a_bypass_follows: assert property (p_bypass_follows) else $error("bypass lag");

    property p_filter_holds;
        @(posedge sys_clk) disable iff (reset)
        (ch_active[1] && s_r.detect_enable[smc_pkg::DE_DET1]
         && !s_r.ch0_control[smc_pkg::C0_BYPASS] && !tick_r) |=> $stable(ch_level[1]);
    endproperty
    a_filter_holds: assert property (p_filter_holds) else $error("level moved off tick");

    c_irq: cover property (@(posedge sys_clk) disable iff (reset) $rose(irq));
    c_ch0_reset: cover property (@(posedge sys_clk) disable iff (reset) $rose(ch0_reset_req));
    c_active2: cover property (@(posedge sys_clk) disable iff (reset) $rose(ch_active[2]));
    c_ch1_fall: cover property (@(posedge sys_clk) disable iff (reset) $fell(ch_level[1]));
endmodule
`default_nettype wire

/* tb.sv */
// tb: self-checking bench for smc_top through its register port and pins
// assumes: smc_pkg compiled first; one 50 MHz clock, slow oscillator made here
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DLY = 10;
    localparam int SP  = 8; // slow oscillator period in sys_clk cycles
    logic       sys_clk = 1'b0;
    logic       reset   = 1'b1;
    logic       soft_reset = 1'b0;
    logic       opt     = 1'b0;
    logic       slow    = 1'b0;
    logic [2:0] cmp     = 3'h7;
    logic [7:0] addr    = 8'h00;
    logic [7:0] wdata   = 8'h00;
    logic       wr      = 1'b0;
    logic       rd      = 1'b0;
    logic       rd_d    = 1'b0;
    logic [7:0] rdata;
    logic [7:0] last_rd;
    logic       irq;
    logic       rreq;
    logic       lce;
    logic [7:0] qv[$];
    logic [7:0] qm[$];
    int         n_errors = 0;
    int         comparisons = 0;
    int         cyc = 0;

    smc_top #(.DELAY_CYC(DLY)) dut_u (
        .sys_clk(sys_clk), .reset(reset), .soft_reset(soft_reset),
        .startup_det0_option(opt), .slow_oscillator_clock(slow), .cmp_above(cmp),
        .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
        .reg_rdata(rdata), .irq(irq), .ch0_reset_req(rreq),
        .low_consumption_enable(lce));

    initial forever #10 sys_clk = ~sys_clk;
    initial forever begin
        repeat (SP / 2) @(posedge sys_clk);
        slow <= ~slow;
    end
    always @(posedge sys_clk) begin
        rd_d <= rd;
        cyc  <= cyc + 1;
    end

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic fail(input logic [7:0] e, input logic [7:0] g);
        n_errors++;
        $display("[FAIL] %0t exp %h got %h", $time, e, g);
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) fail(e, g);
    endtask
    // read data stand one cycle only, so the monitor samples mid-cycle
    always @(negedge sys_clk) if (rd_d) begin
        logic [7:0] v;
        logic [7:0] m;
        v = qv.pop_front();
        m = qm.pop_front();
        last_rd = rdata;
        if (m != 8'h00) chk(rdata & m, v);
    end
    task automatic wrr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask
    task automatic rdr(input logic [7:0] a, input logic [7:0] v, input logic [7:0] m);
        @(posedge sys_clk);
        addr <= a;
        rd   <= 1'b1;
        qv.push_back(v & m);
        qm.push_back(m);
        @(posedge sys_clk);
        rd <= 1'b0;
    endtask
    // mask 0 in the queue: value is kept in last_rd, not compared
    task automatic poll(input logic [7:0] a, input logic [7:0] m, input logic [7:0] v,
                        input int b, output int t);
        t = -1;
        for (int i = 0; i < b && t < 0; i++) begin
            rdr(a, 8'h00, 8'h00);
            @(negedge sys_clk);
            #1;
            if ((last_rd & m) === v) t = cyc;
        end
        comparisons++;
        if (t < 0) begin
            fail(v, last_rd & m);
            end_of_test();
        end
        // realign so the caller drives on a rising edge
        @(posedge sys_clk);
    endtask
    // sampled at falling edges, away from the edge that launches the output
    task automatic waitp(input int w, input logic e, input int b, output int n);
        n = 0;
        @(negedge sys_clk);
        while (((w == 0) ? irq : rreq) !== e && n < b) begin
            @(negedge sys_clk);
            n++;
        end
        comparisons++;
        if (((w == 0) ? irq : rreq) !== e) begin
            fail(8'(e), 8'(!e));
            end_of_test();
        end
        @(posedge sys_clk);
    endtask
    task automatic done(input string s);
        $display("test %s done", s);
    endtask

    initial begin
        int t0;
        int t;
        int n;
        int d;
        int prev;
        logic [7:0] r;
        r = 8'($urandom(5168));
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        rdr(smc_pkg::OFF_DETECT_ENABLE, smc_pkg::DE_RST_OPT0, 8'hff);
        rdr(smc_pkg::OFF_CH0_CONTROL, smc_pkg::C0_RST_OPT0, 8'hf7);
        rdr(smc_pkg::OFF_LEVEL_STATUS, smc_pkg::LS_RST, 8'hff);
        chk(8'(lce), 8'h00);
        for (int i = 0; i < 4; i++) rdr(8'h40 | 8'($urandom() & 8'h3f), 8'h00, 8'hff);
        done("reset values");
        wrr(smc_pkg::OFF_DETECT_ENABLE, 8'($urandom()));
        wrr(smc_pkg::OFF_CH0_CONTROL, 8'($urandom()));
        rdr(smc_pkg::OFF_DETECT_ENABLE, smc_pkg::DE_RST_OPT0, 8'hff);
        rdr(smc_pkg::OFF_CH0_CONTROL, smc_pkg::C0_RST_OPT0, 8'hf7);
        done("write protect");
        wrr(smc_pkg::OFF_PROTECT, 8'h01);
        wrr(smc_pkg::OFF_DETECT_ENABLE, 8'hff);
        rdr(smc_pkg::OFF_DETECT_ENABLE, smc_pkg::DE_WMASK, 8'hff);
        chk(8'(lce), 8'h01);
        wrr(smc_pkg::OFF_DETECT_ENABLE, 8'h00);
        cmp[2] <= 1'b0;
        repeat (40) @(posedge sys_clk);
        rdr(smc_pkg::OFF_LEVEL_STATUS, 8'h08, 8'h08);
        wrr(smc_pkg::OFF_IRQ_STATUS, 8'h07);
        wrr(smc_pkg::OFF_DETECT_ENABLE, 8'h80);
        t0 = cyc;
        rdr(smc_pkg::OFF_LEVEL_STATUS, 8'h08, 8'h08);
        poll(smc_pkg::OFF_LEVEL_STATUS, 8'h08, 8'h00, 300, t);
        chk(8'(t - t0 >= DLY), 8'h01);
        rdr(smc_pkg::OFF_IRQ_STATUS, 8'h04, 8'h04);
        cmp[2] <= 1'b1;
        poll(smc_pkg::OFF_LEVEL_STATUS, 8'h08, 8'h08, 300, t);
        cmp[2] <= 1'b0;
        poll(smc_pkg::OFF_LEVEL_STATUS, 8'h08, 8'h00, 300, t);
        wrr(smc_pkg::OFF_DETECT_ENABLE, 8'h00);
        poll(smc_pkg::OFF_LEVEL_STATUS, 8'h08, 8'h08, 20, t);
        done("channel 2 level");
        wrr(smc_pkg::OFF_DETECT_ENABLE, 8'he0);
        poll(smc_pkg::OFF_LEVEL_STATUS, 8'h08, 8'h00, 300, t);
        @(posedge sys_clk);
        soft_reset <= 1'b1;
        @(posedge sys_clk);
        soft_reset <= 1'b0;
        rdr(smc_pkg::OFF_DETECT_ENABLE, 8'he0, 8'hff);
        rdr(smc_pkg::OFF_LEVEL_STATUS, 8'h00, 8'h08);
        rdr(smc_pkg::OFF_CH0_CONTROL, smc_pkg::C0_RST_OPT0, 8'hf7);
        cmp[2] <= 1'b1;
        done("soft reset");
        prev = 0;
        for (int c = 0; c < 4; c++) begin
            d = 1 << c;
            wrr(smc_pkg::OFF_CH0_CONTROL, {2'b00, 2'(c), 4'h0});
            wrr(smc_pkg::OFF_IRQ_MASK, 8'h02);
            repeat (8 * SP * d) @(posedge sys_clk);
            wrr(smc_pkg::OFF_IRQ_STATUS, 8'h07);
            cmp[1] <= 1'b0;
            waitp(0, 1'b1, 1200, n);
            chk(8'(n >= (smc_pkg::FILT_SAMPLES - 1) * d * SP), 8'h01);
            chk(8'(n <= smc_pkg::FILT_SAMPLES * d * SP + 2 * SP), 8'h01);
            chk(8'(n > prev), 8'h01);
            prev = n;
            cmp[1] <= 1'b1;
            repeat (150 * d) @(posedge sys_clk);
        end
        // bypass path: masked event, then unmask, then clear by writing one
        wrr(smc_pkg::OFF_CH0_CONTROL, 8'h82);
        wrr(smc_pkg::OFF_IRQ_MASK, 8'h00);
        wrr(smc_pkg::OFF_IRQ_STATUS, 8'h07);
        cmp[1] <= 1'b0;
        repeat (SP) @(posedge sys_clk);
        rdr(smc_pkg::OFF_IRQ_STATUS, 8'h02, 8'h02);
        chk(8'(irq), 8'h00);
        wrr(smc_pkg::OFF_IRQ_MASK, 8'h02);
        waitp(0, 1'b1, 3, n);
        wrr(smc_pkg::OFF_IRQ_STATUS, 8'h02);
        waitp(0, 1'b0, 3, n);
        cmp[1] <= 1'b1;
        repeat (20) @(posedge sys_clk);
        wrr(smc_pkg::OFF_DETECT_ENABLE, 8'ha0);
        wrr(smc_pkg::OFF_IRQ_STATUS, 8'h07);
        cmp[1] <= 1'b0;
        repeat (40) @(posedge sys_clk);
        rdr(smc_pkg::OFF_IRQ_STATUS, 8'h00, 8'h02);
        cmp[1] <= 1'b1;
        done("filter and interrupt");
        wrr(smc_pkg::OFF_CH0_CONTROL, 8'hc3);
        cmp[0] <= 1'b0;
        waitp(1, 1'b1, 40, n);
        wrr(smc_pkg::OFF_DETECT_ENABLE, 8'h80);
        waitp(1, 1'b0, 10, n);
        repeat (2 * DLY) @(posedge sys_clk);
        chk(8'(rreq), 8'h00);
        cmp[0] <= 1'b1;
        done("monitor 0 reset");
        // strap 1 path of a second hard reset in mid-run
        @(posedge sys_clk);
        opt   <= 1'b1;
        reset <= 1'b1;
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        rdr(smc_pkg::OFF_DETECT_ENABLE, smc_pkg::DE_RST_OPT1, 8'hff);
        rdr(smc_pkg::OFF_CH0_CONTROL, smc_pkg::C0_RST_OPT1, 8'hf7);
        rdr(smc_pkg::OFF_LEVEL_STATUS, smc_pkg::LS_RST, 8'hff);
        repeat (3) @(posedge sys_clk);
        done("strap reset");
        end_of_test();
    end
endmodule
`default_nettype wire
